// file: logic/tcm_top.sv
/*
  Two-unit timer, counter and pulse-width modulator with APB register
  access, pin synchronisers, clock dividers and one interrupt line.
  Assumes a single 25 MHz ref_clk; all pins are asynchronous to it.
*/
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "tcm_defs.svh"

// How it works
// - Each unit counts in 16 bits up to a period that software writes.
// - A capture pin edge copies the running count into the capture register.
// - In timer, edge and pseudo-random modes the counter stops at the period in one-shot mode or else reloads to zero.
// - The count, or in pseudo-random mode the LFSR value, is compared with the compare register to form the PWM duty signal.
// - True and complementary outputs are separated by a programmable dead gap.
// - While kill is active both outputs take their programmed safe levels.
// - Quadrature mode counts up or down by the phase order of two encoder inputs.
// - Two independent copies of the unit are built.
// - Edge-aligned, center-aligned and pseudo-random PWM modes are offered.
// - Kill can also come from a comparator result when enabled.
module tcm_top import tcm_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] capture_pin,
  input wire logic [1:0] kill_pin,
  input wire logic [1:0] comparator_pin,
  input wire logic [1:0] quad_a_pin,
  input wire logic [1:0] quad_b_pin,
  output logic [1:0] pwm_out,
  output logic [1:0] pwm_out_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    logic [5:0] r;
    r = a[5:0];
    if (a[`TCM_GLOBAL_BIT]) begin
      is_mapped = (a == `TCM_INT_STATUS) || (a == `TCM_INT_MASK);
    end else begin
      is_mapped = (r == `TCM_REG_CTRL) || (r == `TCM_REG_COUNT) ||
                  (r == `TCM_REG_PERIOD) || (r == `TCM_REG_COMPARE) ||
                  (r == `TCM_REG_CAPTURE) || (r == `TCM_REG_DEAD) ||
                  (r == `TCM_REG_DIV);
    end
  endfunction

  function automatic logic unit_hit(input logic [7:0] a, input int u, input logic [5:0] r);
    unit_hit = !a[`TCM_GLOBAL_BIT] && (a[`TCM_UNIT_SEL_BIT] == u[0]) && (a[5:0] == r);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [`TCM_CTRL_W-1:0] ctrl_q [`TCM_UNITS];
  logic [`TCM_CTRL_W-1:0] ctrl_d [`TCM_UNITS];
  logic [15:0] period_q [`TCM_UNITS];
  logic [15:0] period_d [`TCM_UNITS];
  logic [15:0] compare_q [`TCM_UNITS];
  logic [15:0] compare_d [`TCM_UNITS];
  logic [7:0] dead_q [`TCM_UNITS];
  logic [7:0] dead_d [`TCM_UNITS];
  logic [15:0] div_q [`TCM_UNITS];
  logic [15:0] div_d [`TCM_UNITS];
  logic [15:0] divcnt_q [`TCM_UNITS];
  logic [15:0] divcnt_d [`TCM_UNITS];
  logic [`TCM_SYNC_W-1:0] sync1_q [`TCM_UNITS];
  logic [`TCM_SYNC_W-1:0] sync2_q [`TCM_UNITS];
  logic [15:0] count_w [`TCM_UNITS];
  logic [15:0] capture_w [`TCM_UNITS];
  logic [`TCM_EV_W-1:0] evt_w [`TCM_UNITS];
  logic [1:0] tick;
  logic [1:0] load_valid;
  logic [1:0] kill_w;
  logic [1:0] pwm_raw_w;
  logic [`TCM_ST_W-1:0] status_q, status_d, mask_q, mask_d, evt_all, clr;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d, setup, access, wr_en, rd_status;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_en = access & pwrite & is_mapped(paddr);
  // zero wait states: read data, sampled in the setup cycle, is ready in the access cycle
  assign pready = access;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & access;
  assign irq = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // pin synchronisers and dividers, per unit
  // ----------------------------------------------------------------
  genvar gu;
  generate
    for (gu = 0; gu < `TCM_UNITS; gu++) begin : g_unit
      logic [`TCM_SYNC_W-1:0] pins;
      assign pins = {quad_b_pin[gu], quad_a_pin[gu], comparator_pin[gu],
                     kill_pin[gu], capture_pin[gu]};

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sync1_q[gu] <= '0;
          sync2_q[gu] <= '0;
        end else begin
          sync1_q[gu] <= pins;
          sync2_q[gu] <= sync1_q[gu];
        end
      end

      // divider stands for the divided peripheral clock
      assign tick[gu] = (divcnt_q[gu] == div_q[gu]);
      assign load_valid[gu] = wr_en && unit_hit(paddr, gu, `TCM_REG_COUNT);
      assign kill_w[gu] = sync2_q[gu][1] |
                          (ctrl_q[gu][`TCM_CTRL_CMPKILL] & sync2_q[gu][2]);

      tcm_counter u_counter (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick[gu]),
        .enable(ctrl_q[gu][`TCM_CTRL_EN]),
        .one_shot(ctrl_q[gu][`TCM_CTRL_ONESHOT]),
        .mode(tcm_mode_t'(ctrl_q[gu][`TCM_CTRL_MODE_MSB:`TCM_CTRL_MODE_LSB])),
        .cap_edge(tcm_edge_t'(ctrl_q[gu][`TCM_CTRL_EDGE_MSB:`TCM_CTRL_EDGE_LSB])),
        .period(period_q[gu]),
        .compare(compare_q[gu]),
        .load_valid(load_valid[gu]),
        .load_value(pwdata[15:0]),
        .capture_in(sync2_q[gu][0]),
        .quad_a(sync2_q[gu][3]),
        .quad_b(sync2_q[gu][4]),
        .count_q(count_w[gu]),
        .capture_q(capture_w[gu]),
        .evt_q(evt_w[gu]),
        .pwm_raw_q(pwm_raw_w[gu])
      );

      tcm_deadband u_dead (
        .ref_clk(ref_clk),
        .rst(rst),
        .pwm_raw(pwm_raw_w[gu]),
        .dead_len(dead_q[gu]),
        .kill(kill_w[gu]),
        .kill_lvl_t(ctrl_q[gu][`TCM_CTRL_KILL_T]),
        .kill_lvl_c(ctrl_q[gu][`TCM_CTRL_KILL_C]),
        .out_t_q(pwm_out[gu]),
        .out_c_q(pwm_out_n[gu])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes and dividers
  // ----------------------------------------------------------------
  always_comb begin
    for (int u = 0; u < `TCM_UNITS; u++) begin
      ctrl_d[u] = ctrl_q[u];
      period_d[u] = period_q[u];
      compare_d[u] = compare_q[u];
      dead_d[u] = dead_q[u];
      div_d[u] = div_q[u];
      divcnt_d[u] = tick[u] ? 16'h0000 : divcnt_q[u] + 16'h0001;
      if (!ctrl_q[u][`TCM_CTRL_EN]) begin
        divcnt_d[u] = 16'h0000;
      end
      if (wr_en && unit_hit(paddr, u, `TCM_REG_CTRL)) begin
        ctrl_d[u] = pwdata[`TCM_CTRL_W-1:0];
      end
      if (wr_en && unit_hit(paddr, u, `TCM_REG_PERIOD)) begin
        period_d[u] = pwdata[15:0];
      end
      if (wr_en && unit_hit(paddr, u, `TCM_REG_COMPARE)) begin
        compare_d[u] = pwdata[15:0];
      end
      if (wr_en && unit_hit(paddr, u, `TCM_REG_DEAD)) begin
        dead_d[u] = pwdata[7:0];
      end
      if (wr_en && unit_hit(paddr, u, `TCM_REG_DIV)) begin
        div_d[u] = pwdata[15:0];
        divcnt_d[u] = 16'h0000;
      end
    end
    mask_d = mask_q;
    if (wr_en && paddr == `TCM_INT_MASK) begin
      mask_d = pwdata[`TCM_ST_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int u = 0; u < `TCM_UNITS; u++) begin
        ctrl_q[u] <= `TCM_CTRL_RST;
        period_q[u] <= `TCM_PERIOD_RST;
        compare_q[u] <= `TCM_COMPARE_RST;
        dead_q[u] <= `TCM_DEAD_RST;
        div_q[u] <= `TCM_DIV_RST;
        divcnt_q[u] <= 16'h0000;
      end
      mask_q <= '0;
    end else begin
      for (int u = 0; u < `TCM_UNITS; u++) begin
        ctrl_q[u] <= ctrl_d[u];
        period_q[u] <= period_d[u];
        compare_q[u] <= compare_d[u];
        dead_q[u] <= dead_d[u];
        div_q[u] <= div_d[u];
        divcnt_q[u] <= divcnt_d[u];
      end
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  // only bits already returned in the read are cleared; a set wins
  assign evt_all = {evt_w[1], evt_w[0]};
  assign rd_status = access & ~pwrite & (paddr == `TCM_INT_STATUS);
  assign clr = rd_status ? prdata_q[`TCM_ST_W-1:0] : '0;

  always_comb begin
    status_d = (status_q & ~clr) | evt_all;
  end

  // ----------------------------------------------------------------
  // read data, sampled in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      pslverr_d = ~is_mapped(paddr);
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == `TCM_INT_STATUS) begin
          prdata_d[`TCM_ST_W-1:0] = status_q;
        end else if (paddr == `TCM_INT_MASK) begin
          prdata_d[`TCM_ST_W-1:0] = mask_q;
        end else if (!paddr[`TCM_GLOBAL_BIT]) begin
          case (paddr[5:0])
            `TCM_REG_CTRL: prdata_d[`TCM_CTRL_W-1:0] = ctrl_q[paddr[`TCM_UNIT_SEL_BIT]];
            `TCM_REG_COUNT: prdata_d[15:0] = count_w[paddr[`TCM_UNIT_SEL_BIT]];
            `TCM_REG_PERIOD: prdata_d[15:0] = period_q[paddr[`TCM_UNIT_SEL_BIT]];
            `TCM_REG_COMPARE: prdata_d[15:0] = compare_q[paddr[`TCM_UNIT_SEL_BIT]];
            `TCM_REG_CAPTURE: prdata_d[15:0] = capture_w[paddr[`TCM_UNIT_SEL_BIT]];
            `TCM_REG_DEAD: prdata_d[7:0] = dead_q[paddr[`TCM_UNIT_SEL_BIT]];
            `TCM_REG_DIV: prdata_d[15:0] = div_q[paddr[`TCM_UNIT_SEL_BIT]];
            default: prdata_d = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= '0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      status_q <= status_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end
endmodule

// file: logic/tcm_defs.svh
/*
  Register offsets, field positions, reset values and constants of the
  timer, counter and modulator block. Definitions only; included by the
  package and every design file that needs a number.
*/
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define TCM_UNITS 2
`define TCM_UNIT_SEL_BIT 6
`define TCM_GLOBAL_BIT 7
`define TCM_REG_CTRL 6'h00
`define TCM_REG_COUNT 6'h04
`define TCM_REG_PERIOD 6'h08
`define TCM_REG_COMPARE 6'h0C
`define TCM_REG_CAPTURE 6'h10
`define TCM_REG_DEAD 6'h14
`define TCM_REG_DIV 6'h18
`define TCM_INT_STATUS 8'h80
`define TCM_INT_MASK 8'h84

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define TCM_CTRL_EN 0
`define TCM_CTRL_ONESHOT 1
`define TCM_CTRL_MODE_LSB 2
`define TCM_CTRL_MODE_MSB 4
`define TCM_CTRL_CMPKILL 5
`define TCM_CTRL_KILL_T 6
`define TCM_CTRL_KILL_C 7
`define TCM_CTRL_EDGE_LSB 8
`define TCM_CTRL_EDGE_MSB 9
`define TCM_CTRL_W 10

// ----------------------------------------------------------------
// events and reset values
// ----------------------------------------------------------------
`define TCM_EV_CAP 0
`define TCM_EV_CMP 1
`define TCM_EV_PER 2
`define TCM_EV_W 3
`define TCM_ST_W 6
`define TCM_CTRL_RST 10'h000
`define TCM_PERIOD_RST 16'hFFFF
`define TCM_COMPARE_RST 16'h0000
`define TCM_DEAD_RST 8'h00
`define TCM_DIV_RST 16'h0000
`define TCM_LFSR_SEED 16'hACE1
`define TCM_SYNC_W 5

`endif

// file: logic/tcm_pkg.sv
/*
  Types shared by the timer, counter and modulator files.
  Assumes tcm_defs.svh is on the include path.
*/
package tcm_pkg;
  `include "tcm_defs.svh"

  typedef enum logic [2:0] {
    TCM_TIMER,
    TCM_PWM_EDGE,
    TCM_PWM_CENTER,
    TCM_PWM_PRNG,
    TCM_QUAD
  } tcm_mode_t;

  typedef enum logic [1:0] {
    TCM_EDGE_RISE,
    TCM_EDGE_FALL,
    TCM_EDGE_BOTH,
    TCM_EDGE_OFF
  } tcm_edge_t;
endpackage

// file: logic/tcm_counter.sv
/*
  One 16-bit counter with period, compare, capture, pseudo-random source
  and quadrature decoding. Inputs arrive already synchronised to ref_clk;
  tick is a one-cycle enable from the divider in the top.
*/
`timescale 1ns/1ps
`include "tcm_defs.svh"
module tcm_counter import tcm_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic one_shot,
  input tcm_mode_t mode,
  input tcm_edge_t cap_edge,
  input wire logic [15:0] period,
  input wire logic [15:0] compare,
  input wire logic load_valid,
  input wire logic [15:0] load_value,
  input wire logic capture_in,
  input wire logic quad_a,
  input wire logic quad_b,
  output logic [15:0] count_q,
  output logic [15:0] capture_q,
  output logic [`TCM_EV_W-1:0] evt_q,
  output logic pwm_raw_q
);
  logic [15:0] count_d, capture_d, lfsr_q, lfsr_d;
  logic [`TCM_EV_W-1:0] evt_d;
  logic pwm_raw_d, dir_q, dir_d, run_q, run_d;
  logic cap_prev_q, cap_prev_d, qa_q, qa_d, qb_q, qb_d, cap_hit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    capture_d = capture_q;
    lfsr_d = lfsr_q;
    dir_d = dir_q;
    run_d = run_q;
    evt_d = '0;
    cap_prev_d = capture_in;
    qa_d = qa_q;
    qb_d = qb_q;
    case (cap_edge)
      TCM_EDGE_RISE: cap_hit = capture_in & ~cap_prev_q;
      TCM_EDGE_FALL: cap_hit = ~capture_in & cap_prev_q;
      TCM_EDGE_BOTH: cap_hit = capture_in ^ cap_prev_q;
      default: cap_hit = 1'b0;
    endcase
    if (enable && cap_hit) begin
      capture_d = count_q;
      evt_d[`TCM_EV_CAP] = 1'b1;
    end
    if (!enable) begin
      count_d = '0;
      dir_d = 1'b0;
      run_d = 1'b1;
      lfsr_d = `TCM_LFSR_SEED;
      qa_d = quad_a;
      qb_d = quad_b;
    end else if (load_valid) begin
      count_d = load_value;
    end else if (tick && run_q) begin
      lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      evt_d[`TCM_EV_CMP] = (count_q == compare);
      case (mode)
        TCM_QUAD: begin
          qa_d = quad_a;
          qb_d = quad_b;
          if ((quad_a != qa_q) || (quad_b != qb_q)) begin
            // phase order gives direction: b leading a counts up
            if (qa_q ^ quad_b) begin
              count_d = (count_q == period) ? 16'h0000 : count_q + 16'h0001;
              evt_d[`TCM_EV_PER] = (count_q == period);
            end else begin
              count_d = (count_q == 16'h0000) ? period : count_q - 16'h0001;
            end
          end
        end
        TCM_PWM_CENTER: begin
          if (!dir_q) begin
            if (count_q >= period) begin
              dir_d = 1'b1;
              count_d = count_q - 16'h0001;
              evt_d[`TCM_EV_PER] = 1'b1;
            end else begin
              count_d = count_q + 16'h0001;
            end
          end else if (count_q == 16'h0000) begin
            dir_d = 1'b0;
            count_d = 16'h0001;
          end else begin
            count_d = count_q - 16'h0001;
          end
        end
        default: begin
          if (count_q == period) begin
            evt_d[`TCM_EV_PER] = 1'b1;
            if (one_shot) begin
              run_d = 1'b0;
            end else begin
              count_d = '0;
            end
          end else begin
            count_d = count_q + 16'h0001;
          end
        end
      endcase
    end
    // the prng compare makes a duty-correct but spectrally spread output
    if (!enable || mode == TCM_QUAD) begin
      pwm_raw_d = 1'b0;
    end else if (mode == TCM_PWM_PRNG) begin
      pwm_raw_d = lfsr_q < compare;
    end else begin
      pwm_raw_d = count_q < compare;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= '0;
      capture_q <= '0;
      lfsr_q <= `TCM_LFSR_SEED;
      dir_q <= 1'b0;
      run_q <= 1'b1;
      evt_q <= '0;
      pwm_raw_q <= 1'b0;
      cap_prev_q <= 1'b0;
      qa_q <= 1'b0;
      qb_q <= 1'b0;
    end else begin
      count_q <= count_d;
      capture_q <= capture_d;
      lfsr_q <= lfsr_d;
      dir_q <= dir_d;
      run_q <= run_d;
      evt_q <= evt_d;
      pwm_raw_q <= pwm_raw_d;
      cap_prev_q <= cap_prev_d;
      qa_q <= qa_d;
      qb_q <= qb_d;
    end
  end
endmodule

// file: logic/tcm_deadband.sv
/*
  Dead-band output stage: true and complementary lines with a gap of
  dead_len ref_clk cycles after each change, and a kill override.
  Assumes kill is already synchronised.
*/
`timescale 1ns/1ps
module tcm_deadband (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pwm_raw,
  input wire logic [7:0] dead_len,
  input wire logic kill,
  input wire logic kill_lvl_t,
  input wire logic kill_lvl_c,
  output logic out_t_q,
  output logic out_c_q
);
  logic level_q, level_d, out_t_d, out_c_d;
  logic [7:0] gap_q, gap_d;

  always_comb begin
    level_d = level_q;
    gap_d = gap_q;
    if (pwm_raw != level_q) begin
      level_d = pwm_raw;
      gap_d = dead_len;
    end else if (gap_q != 8'h00) begin
      gap_d = gap_q - 8'h01;
    end
    // both lines low during the gap, so no overlap occurs unless kill levels set both high
    out_t_d = level_q & (gap_q == 8'h00);
    out_c_d = ~level_q & (gap_q == 8'h00);
    if (kill) begin
      out_t_d = kill_lvl_t;
      out_c_d = kill_lvl_c;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_q <= 1'b0;
      gap_q <= 8'h00;
      out_t_q <= 1'b0;
      out_c_q <= 1'b0;
    end else begin
      level_q <= level_d;
      gap_q <= gap_d;
      out_t_q <= out_t_d;
      out_c_q <= out_c_d;
    end
  end
endmodule

// file: test/tcm_top_asserts.sv
/*
  Concurrent checks on the ports of the two-unit timer, counter and modulator.
  Assumes one ref_clk with synchronous active-high rst, a non-zero dead gap on
  unit 0 before its duty signal first rises, and no unit 1 control write while
  the unit 1 kill pin is held.
*/
`timescale 1ns/1ps
module tcm_top_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] capture_pin,
  input wire logic [1:0] kill_pin,
  input wire logic [1:0] comparator_pin,
  input wire logic [1:0] quad_a_pin,
  input wire logic [1:0] quad_b_pin,
  input wire logic [1:0] pwm_out,
  input wire logic [1:0] pwm_out_n,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // bus and output properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking

  sequence s_access;
    psel && penable;
  endsequence
  sequence s_bad_setup;
    psel && !penable && paddr == 8'hF0;
  endsequence

  a_ready_access: assert property (disable iff (rst) s_access |-> pready)
    else $error("pready low in access phase");
  a_ready_setup: assert property (disable iff (rst) psel && !penable |-> !pready)
    else $error("pready high in setup phase");
  a_err_unmapped: assert property (disable iff (rst) s_bad_setup ##1 s_access |-> pslverr)
    else $error("no error on unmapped access");
  a_err_access_only: assert property (disable iff (rst) pslverr |-> s_access)
    else $error("pslverr outside access phase");
  a_reset_outputs: assert property (rst |=> pwm_out == 2'h0 && pwm_out_n == 2'h0 && !irq)
    else $error("outputs not cleared by reset");
  a_reset_bus: assert property (rst |=> prdata == 32'h0 && !pslverr)
    else $error("bus outputs not cleared by reset");
  // kill needs sync plus output register, so five samples settle it
  a_kill_hold: assert property (disable iff (rst) kill_pin[1] [*5] |->
    $stable(pwm_out[1]) && $stable(pwm_out_n[1]))
    else $error("outputs move while kill held");
  a_dead_true: assert property (disable iff (rst) $rose(pwm_out[0]) |-> !$past(pwm_out_n[0]))
    else $error("true output rose without gap");
  a_dead_compl: assert property (disable iff (rst) $rose(pwm_out_n[0]) |-> !$past(pwm_out[0]))
    else $error("complement output rose without gap");
  a_irq_fall: assert property (disable iff (rst) !$past(rst) && $fell(irq) |->
    $past(psel && penable))
    else $error("irq dropped without a register access");
endmodule

bind tcm_top tcm_top_asserts tcm_top_asserts_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin), .kill_pin(kill_pin),
  .comparator_pin(comparator_pin), .quad_a_pin(quad_a_pin), .quad_b_pin(quad_b_pin),
  .pwm_out(pwm_out), .pwm_out_n(pwm_out_n), .irq(irq));

// file: test/tcm_pins.sv
/*
  Pin-side model: capture, kill, comparator and encoder lines of both units.
  Assumes the bench calls its tasks; every change lands just after a ref_clk edge.
*/
`timescale 1ns/1ps
module tcm_pins #(
  parameter int GAP = 4
) (
  input wire logic ref_clk,
  output logic [1:0] capture_pin,
  output logic [1:0] kill_pin,
  output logic [1:0] comparator_pin,
  output logic [1:0] quad_a_pin,
  output logic [1:0] quad_b_pin
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [1:0] pos [2];

  initial begin
    capture_pin = 2'h0;
    kill_pin = 2'h0;
    comparator_pin = 2'h0;
    quad_a_pin = 2'h0;
    quad_b_pin = 2'h0;
    pos[0] = 2'h0;
    pos[1] = 2'h0;
  end

  // held long enough to pass the two-flop synchroniser
  task automatic pulse_cap(input int u);
    @(posedge ref_clk);
    capture_pin[u] <= 1'b1;
    repeat (GAP) @(posedge ref_clk);
    capture_pin[u] <= 1'b0;
  endtask

  task automatic set_kill(input int u, input logic k, input logic c);
    @(posedge ref_clk);
    kill_pin[u] <= k;
    comparator_pin[u] <= c;
  endtask

  // gray order 00,01,11,10 counts up; one phase changes per step
  task automatic step(input int u, input logic up);
    logic [1:0] np;
    np = up ? pos[u] + 2'h1 : pos[u] - 2'h1;
    @(posedge ref_clk);
    pos[u] <= np;
    quad_a_pin[u] <= np[1];
    quad_b_pin[u] <= np[1] ^ np[0];
    repeat (GAP) @(posedge ref_clk);
  endtask
endmodule

// file: test/tcm_top_test.sv
/*
  Self-checking bench for the two-unit timer, counter and modulator.
  Assumes tcm_pins and the checker bind are compiled before it.
*/
`timescale 1ns/1ps
module tcm_top_test;
  // ----------------------------------------------------------------
  // signals and helpers
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq;
  logic [1:0] capture_pin, kill_pin, comparator_pin, quad_a_pin, quad_b_pin, pwm_out, pwm_out_n;
  logic [32:0] exp_q [$];
  logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h60201399;

  always #20 ref_clk = ~ref_clk;

  tcm_top tcm_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin(capture_pin), .kill_pin(kill_pin),
    .comparator_pin(comparator_pin), .quad_a_pin(quad_a_pin), .quad_b_pin(quad_b_pin),
    .pwm_out(pwm_out), .pwm_out_n(pwm_out_n), .irq(irq));
  tcm_pins tcm_pins_i (.ref_clk(ref_clk), .capture_pin(capture_pin), .kill_pin(kill_pin),
    .comparator_pin(comparator_pin), .quad_a_pin(quad_a_pin), .quad_b_pin(quad_b_pin));

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // read notes {pslverr, prdata} expected; the monitor below compares it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int c, d, hi_t, hi_c;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (int u = 0; u < 2; u++)
      for (int i = 0; i < 7; i++)
        rd(8'(u * 64) | offs[i], (offs[i] == 8'h08) ? 33'hFFFF : 33'h0);
    rd(8'h84, 33'h0);
    rd(8'hF0, 33'h100000000);
    wr(8'h10, $random(seed));
    rd(8'h10, 33'h0);
    // one-shot timer, period 9, irq on period match
    wr(8'h84, 32'h4);
    wr(8'h08, 32'd9);
    wr(8'h00, 32'h3);
    cyc(40);
    @(negedge ref_clk);
    check({32'h0, irq}, 33'h1);
    rd(8'h04, 33'd9);
    wr(8'h84, 32'h0);
    @(negedge ref_clk);
    check({32'h0, irq}, 33'h0);
    wr(8'h84, 32'h4);
    rd(8'h80, 33'h6);
    @(negedge ref_clk);
    check({32'h0, irq}, 33'h0);
    tcm_pins_i.pulse_cap(0);
    cyc(6);
    rd(8'h10, 33'd9);
    rd(8'h80, 33'h1);
    cyc(40);
    rd(8'h80, 33'h0);
    // reload: period events keep coming
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    cyc(30);
    rd(8'h80, 33'h6);
    cyc(30);
    rd(8'h80, 33'h6);
    // every modulator mode with compare 0 keeps the duty signal low
    d = 1 + ($unsigned($random(seed)) % 3);
    c = 4 + ($unsigned($random(seed)) % 9);
    wr(8'h14, 32'(d));
    for (int m = 1; m < 4; m++) begin
      wr(8'h00, 32'(m * 4 + 1));
      cyc(30);
      @(negedge ref_clk);
      check({31'h0, pwm_out[0], pwm_out_n[0]}, 33'h1);
    end
    // ten periods each: edge 20 cycles, center 0 up to 19 and back, 38 cycles
    wr(8'h08, 32'd19);
    wr(8'h0C, 32'(c));
    for (int m = 1; m < 3; m++) begin
      wr(8'h00, 32'(m * 4 + 1));
      cyc(80);
      hi_t = 0;
      hi_c = 0;
      repeat (m * 180 + 20) begin
        @(negedge ref_clk);
        if (pwm_out[0] === 1'b1) hi_t++;
        if (pwm_out_n[0] === 1'b1) hi_c++;
      end
      check(33'(hi_t), 33'(10 * (m * (c - 1) + 1 - d)));
      check(33'(hi_c), 33'(10 * (19 * m + 1 - m * c - d)));
    end
    // kill from pin and from comparator, levels high on unit 1
    for (int k = 0; k < 4; k++) begin
      wr(8'h40, k < 2 ? 32'hC5 : 32'hE5);
      tcm_pins_i.set_kill(1, k % 2 == 1, k % 2 == 0);
      cyc(6);
      @(negedge ref_clk);
      check({31'h0, pwm_out[1], pwm_out_n[1]}, k == 0 ? 33'h1 : 33'h3);
      tcm_pins_i.set_kill(1, 1'b0, 1'b0);
      cyc(6);
    end
    // quadrature on unit 1: 8 up, 3 down, then wrap below zero
    wr(8'h40, 32'h0);
    wr(8'h40, 32'h11);
    repeat (8) tcm_pins_i.step(1, 1'b1);
    repeat (3) tcm_pins_i.step(1, 1'b0);
    cyc(4);
    rd(8'h44, 33'd5);
    repeat (6) tcm_pins_i.step(1, 1'b0);
    cyc(4);
    rd(8'h44, 33'hFFFF);
    cyc(2);
    finish_test();
  end
endmodule
